// File: hw/rlr_adapted_coefficient_status_mem.sv
// Coefficient table memory with a registered read port.
// Assumes one writer; addresses past the table read as zero.
`timescale 1ns/1ps
module rlr_adapted_coefficient_status_mem #(
  parameter int DEPTH = 48,
  parameter int W = 8
) (
  input wire logic clk, // Core clock.
  input wire logic wr_en, // Write strobe.
  input wire logic [5:0] addr, // Table index.
  input wire logic [W-1:0] wdata, // Write data.
  output logic [W-1:0] rdata // Registered read data.
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] cells;
    logic [W-1:0] rd;
  } rlr_mem_t;
  rlr_mem_t st_reg;
  rlr_mem_t st_next;

  always_comb begin
    st_next = st_reg;
    if (wr_en && (int'(addr) < DEPTH)) begin
      st_next.cells[addr] = wdata;
    end
    st_next.rd = (int'(addr) < DEPTH) ? st_reg.cells[addr] : '0;
  end

  always_ff @(posedge clk) begin
    st_reg <= st_next;
  end

  assign rdata = st_reg.rd;
endmodule

// File: hw/rlr_pkg.sv
// Constants for the receive line interface register bank.
// Assumes an 8-bit parallel processor port sampled on clk.
package rlr_pkg;
  localparam logic [7:0] ADDR_IFC_CFG = 8'h20;
  localparam logic [7:0] ADDR_LINE_STAT = 8'h21;
  localparam logic [7:0] ADDR_RX_CFG = 8'h22;
  localparam logic [7:0] ADDR_LOOP_GAIN = 8'h23;
  localparam logic [7:0] ADDR_GAIN_CEIL = 8'h24;
  localparam logic [7:0] ADDR_COEF_DATA = 8'h25;
  localparam logic [7:0] ADDR_COEF_PTR = 8'h26;
  localparam logic [7:0] ADDR_SLICER = 8'h27;
  localparam logic [7:0] ADDR_OUT_LVL = 8'h28;
  localparam logic [7:0] ADDR_GAIN_STAT = 8'h29;
  localparam logic [7:0] ADDR_PREQ = 8'h2A;
  localparam logic [7:0] ADDR_TAP_FIRST = 8'h30;
  localparam logic [7:0] ADDR_TAP_LAST = 8'h37;
  // Field positions.
  localparam int IFC_RESET_BIT = 7;
  localparam int IFC_SQUELCH_BIT = 6;
  localparam int STAT_VIOL_BIT = 3;
  localparam int STAT_EYE_BIT = 1;
  localparam int STAT_PREQ_BIT = 0;
  localparam int CFG_SHORT_FRZ_BIT = 7;
  localparam int CFG_AGC_HI = 5;
  localparam int CFG_AGC_LO = 4;
  localparam int CFG_COEF_FRZ_BIT = 3;
  localparam int CFG_OOR_BLK_BIT = 2;
  localparam int CFG_BUILD_OUT_BIT = 1;
  localparam int CFG_LONG_EYE_BIT = 0;
  localparam int PREQ_FORCE_BIT = 7;
  localparam int PREQ_ON_BIT = 6;
  localparam int PTR_FIXED_BIT = 7;
  // Reset values.
  localparam logic [7:0] RST_RX_CFG = 8'hB1;
  localparam logic [7:0] RST_GAIN_CEIL = 8'h3F;
  localparam logic [7:0] RST_SLICER = 8'hBA;
  localparam logic [7:0] RST_OUT_LVL = 8'hDA;
  localparam logic [7:0] RST_PREQ = 8'hA6;
  localparam logic [7:0] RST_COEF_DATA = 8'h00;
  localparam logic [5:0] RST_COEF_PTR = 6'h00;
  // Timing counts, in line bit times, and the table size in bytes.
  localparam logic [11:0] AGC_BASE_BITS = 12'h020;
  localparam logic [13:0] EYE_SHORT_BITS = 14'h1000;
  localparam logic [13:0] EYE_LONG_BITS = 14'h2000;
  localparam int COEF_TABLE_BYTES = 48;
  // Error tolerances as counts of a 255 full-scale error: 13, 19, 26, 32 percent.
  localparam logic [7:0] TOL_13 = 8'h21;
  localparam logic [7:0] TOL_19 = 8'h30;
  localparam logic [7:0] TOL_26 = 8'h42;
  localparam logic [7:0] TOL_32 = 8'h52;
  typedef enum logic [1:0] {EYE_SHUT = 2'b01, EYE_OPEN = 2'b10} rlr_eye_t;
endpackage

// File: hw/rlr_regs.sv
// Receive line interface control and status register bank.
// Assumes line-side inputs are synchronous to clk and bit_tick pulses once per line bit.
// How it works
// [R1] Violation flag sets on first qualified violation and holds until the hold interval ends.
// [R2] E1: mode 0 counts every violation, mode 1 only same-polarity consecutive pairs.
// [R3] T1: mode 0 counts all violations, mode 1 skips substitution-coded ones.
// [R4] Every qualified violation also pulses the line code violation counter.
// [R5] Squelch with eye closed forces the data outputs to zero.
// [R6] Eye status reads live: valid signal and locked recovery loop.
// [R7] Status bit shows whether the pre-equalizer is currently engaged.
// [R8] Short-line freeze stops coefficient updates while the received level is strong.
// [R9] Gain window code picks a 32, 128, 512 or 2048 bit update period.
// [R10] Coefficient freeze stops coefficient updates; gain control keeps running.
// [R11] Out-of-range block stops automatic build-out switching while the converter saturates.
// [R12] Build-out enable 0 forces attenuation off, 1 allows automatic switching.
// [R13] Eye timeout bit selects 4096 or 8192 bit times.
// [R14] Applied gain never exceeds the programmed six-bit ceiling.
// [R15] Reset and interface reset reload data, pointer, slicer and pre-equalizer defaults.
// [R16] Six-bit pointer addresses a 48-byte table through the data register.
// [R17] Slicer register holds gain maximum, gain minimum and slicer threshold fields.
// [R18] Acquisition restarts when average error exceeds the first tolerance, default 11.
// [R19] Operation restarts when average error exceeds the second tolerance, default 01.
// [R20] Four-bit output level field selects the target pulse height.
// [R21] Processor writes the gain status register before reading it.
// [R22] Gain status reads the six-bit gain code latched by that write.
// [R23] Pre-equalizer: force 0 automatic, force 1 with on selects on or off.
// [R24] Writing the reset bit restarts the interface and the bit clears itself.
// [R25] Adapted tap status registers are read-only and show live coefficients.
`timescale 1ns/1ps
module rlr_regs #(
  parameter logic [7:0] LOOP_GAIN_RESET = 8'h40
) (
  input wire logic clk, // Core clock, 50 MHz.
  input wire logic reset_n, // Synchronous reset, active low.
  input wire logic [7:0] bus_addr, // Register address.
  input wire logic bus_wr, // Write strobe.
  input wire logic bus_rd, // Read strobe.
  input wire logic [7:0] bus_wdata, // Write data.
  output logic [7:0] bus_rdata, // Read data, valid after bus_rd.
  input wire logic bit_tick, // One pulse per line bit.
  input wire logic viol, // Raw bipolar violation pulse.
  input wire logic viol_pol, // Violation polarity.
  input wire logic viol_in_subst, // Violation inside a substitution code.
  input wire logic line_rate_select, // 1 for T1, 0 for E1.
  input wire logic substitution_count_select, // Substitution counting mode.
  input wire logic hold_expire, // End of the error hold interval.
  input wire logic signal_valid, // Valid receive signal present.
  input wire logic loop_locked, // Clock recovery loop locked.
  input wire logic level_strong, // Received level about -15 dB or stronger.
  input wire logic adc_out_of_range, // Converter out of range.
  input wire logic prequal_auto_req, // Automatic pre-equalizer decision.
  input wire logic in_acquisition, // Equalizer in acquisition state.
  input wire logic [7:0] avg_error, // Average equalizer error.
  input wire logic [5:0] gain_request, // Gain asked by gain control.
  input wire logic [63:0] adapted_taps, // Eight live adapted coefficients.
  input wire logic data_pos_in, // Slicer positive data.
  input wire logic data_neg_in, // Slicer negative data.
  output logic data_pos_out, // Squelched positive data.
  output logic data_neg_out, // Squelched negative data.
  output logic lcv_increment, // Pulse to the violation counter.
  output logic liu_reset, // Interface reset pulse.
  output logic adapted_coefficient_status_update_enable, // Equalizer may adapt.
  output logic agc_update_tick, // Gain control update pulse.
  output logic eye_timeout, // Eye-open timeout pulse.
  output logic eq_restart, // Equalizer restart request.
  output logic build_out_force_off, // Attenuation forced off.
  output logic build_out_switch_ok, // Automatic build-out switching allowed.
  output logic prequal_enable, // Pre-equalizer engaged.
  output logic [5:0] gain_applied, // Gain after ceiling.
  output logic [1:0] agc_max, // Slicer gain maximum field.
  output logic [1:0] agc_min, // Slicer gain minimum field.
  output logic [3:0] slicer_level, // Data slicer threshold.
  output logic [3:0] output_level_target, // Target pulse height code.
  output logic [5:0] prequalizer_threshold, // Pre-equalizer threshold.
  output logic [6:0] recovery_filter_gain // Recovery loop filter gain.
);
  import rlr_pkg::*;

  typedef struct packed {
    logic [7:0] rx_cfg;
    logic [7:0] loop_gain;
    logic [7:0] ceiling;
    logic [7:0] coef_data;
    logic [5:0] coef_ptr;
    logic [7:0] slicer;
    logic [7:0] out_lvl;
    logic [7:0] preq;
    logic [5:0] gain_latch;
    logic squelch;
    logic viol_flag;
    logic rst_pulse;
    logic reload;
    rlr_eye_t eye_state;
    logic [13:0] eye_cnt;
    logic [11:0] agc_cnt;
    logic agc_tick;
    logic eye_tmo;
    logic restart;
    logic line_code_violation_count;
    logic [5:0] gain;
    logic pos;
    logic neg;
    logic [7:0] rdata;
  } rlr_state_t;

  rlr_state_t st_reg;
  rlr_state_t st_next;
  logic viol_hit;
  logic eye_valid;
  logic [7:0] mem_rdata;
  logic mem_wr;

  //////////////////////////////////////////////////////////////////////////////

  function automatic logic [11:0] agc_period(input logic [1:0] code);
    agc_period = AGC_BASE_BITS << {code, 1'b0};
  endfunction

  function automatic logic [7:0] tolerance(input logic [1:0] code);
    case (code)
      2'b00: tolerance = TOL_13;
      2'b01: tolerance = TOL_19;
      2'b10: tolerance = TOL_26;
      default: tolerance = TOL_32;
    endcase
  endfunction

  function automatic logic [5:0] clamp_gain(input logic [5:0] req, input logic [5:0] ceil);
    clamp_gain = (req > ceil) ? ceil : req;
  endfunction

  //////////////////////////////////////////////////////////////////////////////

  rlr_viol_qual u_viol (
    .clk(clk),
    .reset_n(reset_n),
    .viol(viol),
    .viol_pol(viol_pol),
    .viol_in_subst(viol_in_subst),
    .line_rate_select(line_rate_select),
    .substitution_count_select(substitution_count_select),
    .hit(viol_hit)
  );

  assign mem_wr = bus_wr && (bus_addr == ADDR_COEF_DATA);

  // The table sees the next pointer, so a reload after a pointer write fetches the new entry.
  rlr_adapted_coefficient_status_mem #(
    .DEPTH(COEF_TABLE_BYTES),
    .W(8)
  ) u_mem (
    .clk(clk),
    .wr_en(mem_wr), // R16
    .addr(st_next.coef_ptr),
    .wdata(bus_wdata),
    .rdata(mem_rdata)
  );

  assign eye_valid = signal_valid && loop_locked; // R6

  //////////////////////////////////////////////////////////////////////////////

  always_comb begin
    st_next = st_reg;
    st_next.rst_pulse = 1'b0;
    st_next.reload = 1'b0;
    st_next.agc_tick = 1'b0;
    st_next.eye_tmo = 1'b0;

    // A new pointer loads the data register one cycle later; a data write in that cycle wins.
    if (st_reg.reload) begin
      st_next.coef_data = mem_rdata; // R16
    end

    // Register writes.
    if (bus_wr) begin
      if (bus_addr == ADDR_IFC_CFG) begin
        st_next.rst_pulse = bus_wdata[IFC_RESET_BIT]; // R24
        st_next.squelch = bus_wdata[IFC_SQUELCH_BIT];
      end else if (bus_addr == ADDR_RX_CFG) begin
        st_next.rx_cfg = bus_wdata;
      end else if (bus_addr == ADDR_LOOP_GAIN) begin
        st_next.loop_gain = {1'b0, bus_wdata[6:0]};
      end else if (bus_addr == ADDR_GAIN_CEIL) begin
        st_next.ceiling = {2'b00, bus_wdata[5:0]};
      end else if (bus_addr == ADDR_COEF_DATA) begin
        st_next.coef_data = bus_wdata; // R16
      end else if (bus_addr == ADDR_COEF_PTR) begin
        st_next.coef_ptr = bus_wdata[5:0]; // R16
        st_next.reload = 1'b1;
      end else if (bus_addr == ADDR_SLICER) begin
        st_next.slicer = bus_wdata; // R17
      end else if (bus_addr == ADDR_OUT_LVL) begin
        st_next.out_lvl = bus_wdata;
      end else if (bus_addr == ADDR_GAIN_STAT) begin
        st_next.gain_latch = st_reg.gain; // R21 R22
      end else if (bus_addr == ADDR_PREQ) begin
        st_next.preq = bus_wdata;
      end
    end

    // Violation flag: a new violation beats the hold expiry.
    if (viol_hit) begin
      st_next.viol_flag = 1'b1; // R1
    end else if (hold_expire) begin
      st_next.viol_flag = 1'b0;
    end
    st_next.line_code_violation_count = viol_hit; // R4

    // Gain control update period.
    if (bit_tick) begin
      if (st_reg.agc_cnt >= agc_period(st_reg.rx_cfg[CFG_AGC_HI:CFG_AGC_LO]) - 12'h001) begin
        st_next.agc_cnt = '0;
        st_next.agc_tick = 1'b1; // R9
      end else begin
        st_next.agc_cnt = st_reg.agc_cnt + 12'h001;
      end
    end

    // Eye-open timeout while the eye is shut.
    case (st_reg.eye_state)
      EYE_SHUT: begin
        if (eye_valid) begin
          st_next.eye_state = EYE_OPEN;
          st_next.eye_cnt = '0;
        end else if (bit_tick) begin
          if (st_reg.eye_cnt >= (st_reg.rx_cfg[CFG_LONG_EYE_BIT] ? EYE_LONG_BITS : EYE_SHORT_BITS)
              - 14'h0001) begin
            st_next.eye_cnt = '0;
            st_next.eye_tmo = 1'b1; // R13
          end else begin
            st_next.eye_cnt = st_reg.eye_cnt + 14'h0001;
          end
        end
      end
      EYE_OPEN: begin
        if (!eye_valid) begin
          st_next.eye_state = EYE_SHUT;
          st_next.eye_cnt = '0;
        end
      end
      default: begin
        st_next.eye_state = EYE_SHUT;
        st_next.eye_cnt = '0;
      end
    endcase

    // Equalizer restart on excess average error.
    if (in_acquisition) begin
      st_next.restart = avg_error > tolerance(st_reg.out_lvl[7:6]); // R18
    end else begin
      st_next.restart = avg_error > tolerance(st_reg.out_lvl[5:4]); // R19
    end

    st_next.gain = clamp_gain(gain_request, st_reg.ceiling[5:0]); // R14

    st_next.pos = data_pos_in && !(st_reg.squelch && !eye_valid); // R5
    st_next.neg = data_neg_in && !(st_reg.squelch && !eye_valid); // R5

    // Read data.
    if (bus_rd) begin
      if (bus_addr == ADDR_IFC_CFG) begin
        st_next.rdata = {1'b0, st_reg.squelch, 6'h00};
      end else if (bus_addr == ADDR_LINE_STAT) begin
        st_next.rdata = {4'h0, st_reg.viol_flag, 1'b0, eye_valid, prequal_enable}; // R6 R7
      end else if (bus_addr == ADDR_RX_CFG) begin
        st_next.rdata = st_reg.rx_cfg;
      end else if (bus_addr == ADDR_LOOP_GAIN) begin
        st_next.rdata = st_reg.loop_gain;
      end else if (bus_addr == ADDR_GAIN_CEIL) begin
        st_next.rdata = st_reg.ceiling;
      end else if (bus_addr == ADDR_COEF_DATA) begin
        st_next.rdata = st_reg.coef_data;
      end else if (bus_addr == ADDR_COEF_PTR) begin
        st_next.rdata = {1'b1, 1'b0, st_reg.coef_ptr};
      end else if (bus_addr == ADDR_SLICER) begin
        st_next.rdata = st_reg.slicer;
      end else if (bus_addr == ADDR_OUT_LVL) begin
        st_next.rdata = st_reg.out_lvl;
      end else if (bus_addr == ADDR_GAIN_STAT) begin
        st_next.rdata = {2'b00, st_reg.gain_latch}; // R22
      end else if (bus_addr == ADDR_PREQ) begin
        st_next.rdata = st_reg.preq;
      end else if (bus_addr >= ADDR_TAP_FIRST && bus_addr <= ADDR_TAP_LAST) begin
        st_next.rdata = adapted_taps[bus_addr[2:0]*8 +: 8]; // R25
      end else begin
        st_next.rdata = 8'h00;
      end
    end

    // Interface reset reloads the equalizer defaults and restarts acquisition.
    if (st_reg.rst_pulse) begin
      st_next.coef_data = RST_COEF_DATA; // R15
      st_next.coef_ptr = RST_COEF_PTR; // R15
      st_next.slicer = RST_SLICER; // R15
      st_next.preq = RST_PREQ; // R15
      st_next.reload = 1'b0;
      st_next.eye_state = EYE_SHUT; // R24
      st_next.eye_cnt = '0;
      st_next.agc_cnt = '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_reg <= '{
        rx_cfg: RST_RX_CFG,
        loop_gain: LOOP_GAIN_RESET,
        ceiling: RST_GAIN_CEIL,
        coef_data: RST_COEF_DATA,
        coef_ptr: RST_COEF_PTR,
        slicer: RST_SLICER,
        out_lvl: RST_OUT_LVL,
        preq: RST_PREQ,
        eye_state: EYE_SHUT,
        default: '0
      }; // R15
    end else begin
      st_reg <= st_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  assign bus_rdata = st_reg.rdata;
  assign data_pos_out = st_reg.pos;
  assign data_neg_out = st_reg.neg;
  assign lcv_increment = st_reg.line_code_violation_count;
  assign liu_reset = st_reg.rst_pulse;
  assign agc_update_tick = st_reg.agc_tick;
  assign eye_timeout = st_reg.eye_tmo;
  assign eq_restart = st_reg.restart;
  assign gain_applied = st_reg.gain;

  // Coefficients adapt unless frozen outright or frozen on a short line.
  assign adapted_coefficient_status_update_enable = !st_reg.rx_cfg[CFG_COEF_FRZ_BIT] && // R10
    !(st_reg.rx_cfg[CFG_SHORT_FRZ_BIT] && level_strong); // R8

  assign build_out_force_off = !st_reg.rx_cfg[CFG_BUILD_OUT_BIT]; // R12
  assign build_out_switch_ok = st_reg.rx_cfg[CFG_BUILD_OUT_BIT] &&
    !(st_reg.rx_cfg[CFG_OOR_BLK_BIT] && adc_out_of_range); // R11

  assign prequal_enable = st_reg.preq[PREQ_FORCE_BIT] ? st_reg.preq[PREQ_ON_BIT] : prequal_auto_req; // R23

  assign agc_max = st_reg.slicer[7:6]; // R17
  assign agc_min = st_reg.slicer[5:4]; // R17
  assign slicer_level = st_reg.slicer[3:0]; // R17
  assign output_level_target = st_reg.out_lvl[3:0]; // R20
  assign prequalizer_threshold = st_reg.preq[5:0];
  assign recovery_filter_gain = st_reg.loop_gain[6:0];

  //////////////////////////////////////////////////////////////////////////////

  a_viol_latch: assert property (@(posedge clk) disable iff (!reset_n)
    viol_hit |=> st_reg.viol_flag ##1 (st_reg.viol_flag || $past(hold_expire)))
    else $error("violation flag not latched"); // R1
  a_lcv_pulse: assert property (@(posedge clk) disable iff (!reset_n)
    viol_hit |=> lcv_increment) else $error("counter pulse missing"); // R4
  a_squelch_zero: assert property (@(posedge clk) disable iff (!reset_n)
    (st_reg.squelch && !eye_valid && !bus_wr) |=> (!data_pos_out && !data_neg_out))
    else $error("squelched data not zero"); // R5
  a_eye_status: assert property (@(posedge clk) disable iff (!reset_n)
    (bus_rd && bus_addr == ADDR_LINE_STAT) |=> (bus_rdata[STAT_EYE_BIT] == $past(eye_valid)))
    else $error("eye status wrong"); // R6
  a_coef_freeze: assert property (@(posedge clk) disable iff (!reset_n)
    st_reg.rx_cfg[CFG_COEF_FRZ_BIT] |-> !adapted_coefficient_status_update_enable) else $error("frozen but adapting"); // R10
  a_gain_ceiling: assert property (@(posedge clk) disable iff (!reset_n)
    1'b1 |=> (gain_applied <= $past(st_reg.ceiling[5:0]))) else $error("gain above ceiling"); // R14
  a_reset_reload: assert property (@(posedge clk) disable iff (!reset_n)
    liu_reset |=> (st_reg.slicer == RST_SLICER && st_reg.preq == RST_PREQ && st_reg.coef_ptr == RST_COEF_PTR))
    else $error("defaults not reloaded"); // R15
  a_reset_selfclr: assert property (@(posedge clk) disable iff (!reset_n)
    (bus_wr && bus_addr == ADDR_IFC_CFG && bus_wdata[IFC_RESET_BIT]) |=> liu_reset ##1 !liu_reset)
    else $error("reset bit not self-clearing"); // R24
  a_preq_forced: assert property (@(posedge clk) disable iff (!reset_n)
    (bus_wr && bus_addr == ADDR_PREQ && bus_wdata[7:6] == 2'b10) |=> !prequal_enable)
    else $error("forced off not honoured"); // R23
  a_tap_readonly: assert property (@(posedge clk) disable iff (!reset_n)
    (bus_rd && bus_addr == ADDR_TAP_FIRST) |=> (bus_rdata == $past(adapted_taps[7:0])))
    else $error("tap readback wrong"); // R25
endmodule

// File: hw/rlr_viol_qual.sv
// Qualifies raw bipolar violations by line rate and substitution counting.
// Assumes violation inputs are one-cycle pulses synchronous to clk.
`timescale 1ns/1ps
module rlr_viol_qual (
  input wire logic clk, // Core clock.
  input wire logic reset_n, // Synchronous reset, active low.
  input wire logic viol, // Raw violation pulse.
  input wire logic viol_pol, // Polarity of the violating pulse.
  input wire logic viol_in_subst, // Violation is part of a substitution code.
  input wire logic line_rate_select, // 1 for T1, 0 for E1.
  input wire logic substitution_count_select, // Substitution counting mode.
  output logic hit // Qualified violation pulse.
);
  typedef struct packed {
    logic seen;
    logic last_pol;
    logic hit;
  } rlr_vq_t;
  rlr_vq_t st_reg;
  rlr_vq_t st_next;
  logic qualify;

  always_comb begin
    st_next = st_reg;
    qualify = 1'b0;
    if (viol) begin
      if (!substitution_count_select) begin
        qualify = 1'b1; // R2 R3
      end else if (line_rate_select) begin
        qualify = !viol_in_subst; // R3
      end else begin
        qualify = st_reg.seen && (st_reg.last_pol == viol_pol); // R2
      end
      st_next.seen = 1'b1;
      st_next.last_pol = viol_pol;
    end
    st_next.hit = qualify;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign hit = st_reg.hit;

  a_t1_all_count: assert property (@(posedge clk) disable iff (!reset_n)
    (viol && !substitution_count_select) |=> hit) else $error("violation not counted"); // R2
  a_t1_subst_skip: assert property (@(posedge clk) disable iff (!reset_n)
    (viol && line_rate_select && substitution_count_select && viol_in_subst) |=> !hit)
    else $error("substitution violation counted"); // R3
endmodule

// File: tb/rlr_regs_bench.sv
// Self-checking bench for the receive line interface register bank.
// Assumes rlr_pkg and rlr_regs are compiled first; the bench drives every port itself.
`timescale 1ns/1ps
module rlr_regs_bench;
  import rlr_pkg::*;
  logic clk = 0, reset_n = 0, bus_wr = 0, bus_rd = 0, bit_tick = 1, viol = 0, viol_pol = 0, viol_in_subst = 0;
  logic line_rate_select = 0, substitution_count_select = 0, hold_expire = 0, signal_valid = 0, loop_locked = 0;
  logic level_strong = 0, adc_out_of_range = 0, prequal_auto_req = 1, in_acquisition = 0;
  logic data_pos_in = 1, data_neg_in = 1;
  logic [7:0] bus_addr = 0, bus_wdata = 0, avg_error = 0, bus_rdata, v;
  logic [5:0] gain_request = 6'h30;
  logic [63:0] adapted_taps = 64'h0123_4567_89ab_cdef;
  logic data_pos_out, data_neg_out, lcv_increment, liu_reset, adapted_coefficient_status_update_enable, agc_update_tick, eye_timeout;
  logic eq_restart, build_out_force_off, build_out_switch_ok, prequal_enable;
  logic [5:0] gain_applied, prequalizer_threshold;
  logic [1:0] agc_max, agc_min;
  logic [3:0] slicer_level, output_level_target;
  logic [6:0] recovery_filter_gain;
  logic [15:0] n;
  int bad_count = 0, total_checks = 0;
  rlr_regs i_rlr_regs (.*);
  always #10 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [15:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, d);
    @(posedge clk) begin bus_addr <= a; bus_wdata <= d; bus_wr <= 1; end
    @(posedge clk) bus_wr <= 0;
    #1;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk) begin bus_addr <= a; bus_rd <= 1; end
    @(posedge clk) bus_rd <= 0;
    #1 v = bus_rdata;
  endtask
  task rc(input logic [7:0] a, e);
    rd(a);
    chk(v, e);
  endtask
  // One violation; the counter pulse stands for the second cycle after the strobe is taken.
  task vp(input logic p, s, e);
    @(posedge clk) begin viol <= 1; viol_pol <= p; viol_in_subst <= s; end
    @(posedge clk) viol <= 0;
    @(posedge clk);
    #1 chk(lcv_increment, e);
  endtask
  task er(input logic q, input logic [7:0] x, input logic e);
    @(posedge clk) begin in_acquisition <= q; avg_error <= x; end
    repeat (2) @(posedge clk);
    #1 chk(eq_restart, e);
  endtask
  task pq(input logic [7:0] d, input logic a, e);
    @(posedge clk) prequal_auto_req <= a;
    wr(ADDR_PREQ, d);
    chk(prequal_enable, e);
    chk(prequalizer_threshold, d[5:0]);
    rd(ADDR_LINE_STAT);
    chk(v[STAT_PREQ_BIT], e);
  endtask
  // Waits for one pulse, then counts the cycles to the next one.
  task gap(input bit e);
    int k;
    k = 0;
    do @(posedge clk) #1; while ((e ? eye_timeout : agc_update_tick) !== 1 && k++ < 9000);
    n = 0;
    do begin
      @(posedge clk) #1;
      n++;
    end while ((e ? eye_timeout : agc_update_tick) !== 1 && n < 9000);
  endtask
  task results;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    results;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1;
    rc(ADDR_RX_CFG, RST_RX_CFG);
    rc(ADDR_GAIN_CEIL, RST_GAIN_CEIL);
    rc(ADDR_LOOP_GAIN, 8'h40);
    chk(recovery_filter_gain, 7'h40);
    rc(ADDR_COEF_DATA, RST_COEF_DATA);
    rc(ADDR_COEF_PTR, 8'h80);
    rc(ADDR_SLICER, RST_SLICER);
    rc(ADDR_OUT_LVL, RST_OUT_LVL);
    rc(ADDR_PREQ, RST_PREQ);
    chk(gain_applied, 6'h30);
    chk(output_level_target, 4'ha);
    er(1, TOL_32, 0);
    er(1, TOL_32 + 8'h01, 1);
    er(0, TOL_19, 0);
    er(0, TOL_19 + 8'h01, 1);
    $display("reset values done");
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_RX_CFG, {2'b00, c[1:0], 4'h0});
      gap(0);
      chk(n, 16'h0020 << (2 * c));
    end
    gap(1);
    chk(n, 16'h1000);
    wr(ADDR_RX_CFG, 8'h01);
    gap(1);
    chk(n, 16'h2000);
    $display("timers done");
    wr(ADDR_SLICER, 8'h55);
    chk({agc_max, agc_min, slicer_level}, 8'h55);
    wr(ADDR_OUT_LVL, 8'hc9);
    chk(output_level_target, 4'h9);
    wr(ADDR_GAIN_CEIL, 8'h10);
    @(posedge clk) #1 chk(gain_applied, 6'h10);
    wr(ADDR_GAIN_STAT, 8'h00);
    rc(ADDR_GAIN_STAT, 8'h10);
    for (int k = 0; k < 8; k++) begin
      rc(ADDR_TAP_FIRST + 8'(k), adapted_taps[8*k +: 8]);
    end
    wr(ADDR_TAP_FIRST, 8'hff);
    rc(ADDR_TAP_FIRST, 8'hef);
    rc(8'h3f, 8'h00);
    pq(8'h80, 1, 0);
    pq(8'hc0, 0, 1);
    pq(8'h05, 1, 1);
    pq(8'h4a, 0, 0);
    $display("field tests done");
    chk(data_pos_out, 1);
    wr(ADDR_IFC_CFG, 8'h40);
    repeat (2) @(posedge clk);
    #1 chk({data_pos_out, data_neg_out}, 2'b00);
    @(posedge clk) loop_locked <= 1;
    rd(ADDR_LINE_STAT);
    chk(v[STAT_EYE_BIT], 0);
    @(posedge clk) signal_valid <= 1;
    repeat (2) @(posedge clk);
    #1 chk({data_pos_out, data_neg_out}, 2'b11);
    rd(ADDR_LINE_STAT);
    chk(v[STAT_EYE_BIT], 1);
    vp(0, 0, 1);
    vp(1, 1, 1);
    rd(ADDR_LINE_STAT);
    chk(v[STAT_VIOL_BIT], 1);
    @(posedge clk) hold_expire <= 1;
    @(posedge clk) hold_expire <= 0;
    rd(ADDR_LINE_STAT);
    chk(v[STAT_VIOL_BIT], 0);
    @(posedge clk) substitution_count_select <= 1;
    vp(0, 0, 0);
    vp(0, 0, 1);
    @(posedge clk) begin line_rate_select <= 1; substitution_count_select <= 0; end
    vp(1, 1, 1);
    @(posedge clk) substitution_count_select <= 1;
    vp(1, 1, 0);
    vp(1, 0, 1);
    $display("status tests done");
    wr(ADDR_RX_CFG, 8'h08);
    chk(adapted_coefficient_status_update_enable, 0);
    wr(ADDR_RX_CFG, 8'h00);
    chk({adapted_coefficient_status_update_enable, build_out_force_off}, 2'b11);
    @(posedge clk) begin level_strong <= 1; adc_out_of_range <= 1; end
    wr(ADDR_RX_CFG, 8'h80);
    chk(adapted_coefficient_status_update_enable, 0);
    wr(ADDR_RX_CFG, 8'h06);
    chk({build_out_force_off, build_out_switch_ok}, 2'b00);
    wr(ADDR_RX_CFG, 8'h02);
    chk({build_out_force_off, build_out_switch_ok}, 2'b01);
    wr(ADDR_COEF_PTR, 8'h05);
    wr(ADDR_COEF_DATA, 8'h77);
    wr(ADDR_COEF_PTR, 8'h06);
    wr(ADDR_COEF_DATA, 8'h11);
    wr(ADDR_COEF_PTR, 8'h05);
    repeat (2) @(posedge clk);
    rc(ADDR_COEF_DATA, 8'h77);
    wr(ADDR_COEF_PTR, 8'h30);
    repeat (2) @(posedge clk);
    rc(ADDR_COEF_DATA, 8'h00);
    rc(ADDR_COEF_PTR, 8'hb0);
    wr(ADDR_IFC_CFG, 8'hc0);
    chk(liu_reset, 1);
    rc(ADDR_IFC_CFG, 8'h40);
    rc(ADDR_COEF_DATA, RST_COEF_DATA);
    rc(ADDR_COEF_PTR, 8'h80);
    rc(ADDR_SLICER, RST_SLICER);
    rc(ADDR_PREQ, RST_PREQ);
    rc(ADDR_OUT_LVL, 8'hc9);
    $display("table and reset tests done");
    results;
  end
endmodule
